// [hw/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import stream_regs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire spi_pins_type pins_in,
  output spi_pins_type pins_out
);

  typedef struct packed {
    spi_pins_type meta;
    spi_pins_type stable;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  always_comb begin
    d = q;
    d.meta = pins_in;
    d.stable = q.meta;
  end

  // chip select idles high so no false frame is seen right after reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{meta: '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0},
             stable: '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign pins_out = q.stable;

endmodule : pin_sync
`default_nettype wire

// [hw/stream_regs.sv]
// Behaviour
// RULE1 - maker code readable as two byte registers
// RULE2 - nonzero span: step span times, then restart
// RULE3 - zero span: step whole space, wrapping around
// RULE4 - host writes multibyte registers in one frame
// RULE5 - host addresses byte matching stepping direction
// RULE6 - not-ready flag shows when device cannot accept
// RULE7 - bit 7 enables channel 0 sink
// RULE8 - bits 5..0 are active-low channel shutdowns
// RULE9 - ascension bit picks increment or decrement
// RULE10 - one-instruction mode: one register per frame
// RULE11 - host waits while not-ready flag set
// RULE12 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module stream_regs
  import stream_regs_pkg::*;
#(
  // arbitrary neutral identification value
  parameter logic [15:0] MAKER_CODE = 16'h1A2B
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  input wire logic core_busy_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  output logic first_channel_sink_on_out,
  output logic [CHANNELS-1:0] out_run_n_out
);

  typedef struct packed {
    logic sclk_prev;
    phase_type phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic rd;
    logic [6:0] addr;
    logic [6:0] first_addr;
    logic [7:0] steps;
    logic done_one;
    logic not_ready;
    logic sdo;
    logic sdo_oe;
    regs_type regs;
  } state_type;

  localparam regs_type REGS_RESET = '{
    ascend: 1'b0,
    one_instruction_only: 1'b0,
    stream_span: STREAM_SPAN_RESET,
    first_channel_sink_on: CHANNEL_ENABLE_CONFIG_RESET[SINK_ON_BIT],
    out_run_n: CHANNEL_ENABLE_CONFIG_RESET[CHANNELS-1:0]
  };

  localparam state_type STATE_RESET = '{
    sclk_prev: 1'b0,
    phase: PH_IDLE,
    bit_cnt: 3'h0,
    rx: 8'h00,
    tx: 8'h00,
    rd: 1'b0,
    addr: 7'h00,
    first_addr: 7'h00,
    steps: 8'h00,
    done_one: 1'b0,
    not_ready: 1'b0,
    sdo: 1'b0,
    sdo_oe: 1'b0,
    regs: REGS_RESET
  };

  // unmapped addresses and reserved bits read as zero
  function automatic logic [7:0] reg_read(
    input logic [6:0] a,
    input regs_type r,
    input logic not_ready
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == IF_CONFIG_A_OFFSET) begin
      v = IF_CONFIG_A_FIXED;
      v[ASCEND_HI_BIT] = r.ascend;
      v[ASCEND_LO_BIT] = r.ascend;
    end else if (a == IF_CONFIG_B_OFFSET) begin
      v = IF_CONFIG_B_FIXED;
      v[ONE_INSTRUCTION_BIT] = r.one_instruction_only;
    end else if (a == MAKER_CODE_LOW_OFFSET) begin
      v = MAKER_CODE[7:0]; // [RULE1]
    end else if (a == MAKER_CODE_HIGH_OFFSET) begin
      v = MAKER_CODE[15:8]; // [RULE1]
    end else if (a == STREAM_SPAN_OFFSET) begin
      v = r.stream_span;
    end else if (a == STRICT_WRITE_CONFIG_OFFSET) begin
      v = STRICT_WRITE_CONFIG_RESET; // [RULE4]
    end else if (a == LINK_READY_STATUS_OFFSET) begin
      v[NOT_READY_BIT] = not_ready; // [RULE6]
    end else if (a == CHANNEL_ENABLE_CONFIG_OFFSET) begin
      v[SINK_ON_BIT] = r.first_channel_sink_on; // [RULE7]
      v[CHANNELS-1:0] = r.out_run_n; // [RULE8] [RULE12]
    end
    return v;
  endfunction : reg_read

  spi_pins_type pins_in;
  spi_pins_type pins;
  state_type q;
  state_type d;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] byte_in;
  logic byte_done;

  assign pins_in = '{sclk: spi_sclk_in, cs_n: spi_cs_n_in, sdi: spi_sdi_in};

  pin_sync u_pin_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pins_in(pins_in),
    .pins_out(pins)
  );

  assign sclk_rise = pins.sclk & ~q.sclk_prev;
  assign sclk_fall = ~pins.sclk & q.sclk_prev;
  assign byte_in = {q.rx[6:0], pins.sdi};
  assign byte_done = sclk_rise && (q.bit_cnt == LAST_BIT_INDEX);

  always_comb begin
    d = q;
    d.sclk_prev = pins.sclk;
    // the status flag lags the core by one cycle, harmless next to spi timing
    d.not_ready = core_busy_in; // [RULE6] [RULE11]
    if (pins.cs_n) begin
      d.phase = PH_IDLE;
      d.sdo_oe = 1'b0;
      d.bit_cnt = 3'h0;
      d.tx = 8'h00;
    end else begin
      if (q.phase == PH_IDLE) begin
        d.phase = PH_INSTR;
        d.bit_cnt = 3'h0;
        d.done_one = 1'b0;
      end
      if (sclk_rise) begin
        d.rx = byte_in;
        d.bit_cnt = q.bit_cnt + 3'h1;
      end
      if (sclk_fall) begin
        d.sdo = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
        d.sdo_oe = q.rd && (q.phase == PH_DATA);
      end
      if (byte_done) begin
        case (q.phase)
          PH_INSTR: begin
            d.phase = PH_DATA;
            d.rd = byte_in[READ_FLAG_BIT];
            d.addr = byte_in[6:0];
            d.first_addr = byte_in[6:0];
            d.steps = 8'h00;
            d.tx = reg_read(byte_in[6:0], q.regs, q.not_ready);
          end
          PH_DATA: begin
            if (!q.rd && !(q.regs.one_instruction_only && q.done_one)) begin
              if (q.addr == IF_CONFIG_A_OFFSET) begin
                d.regs.ascend = byte_in[ASCEND_LO_BIT];
                if (byte_in[SOFT_RESET_HI_BIT] && byte_in[SOFT_RESET_LO_BIT]) begin
                  // soft reset keeps the stepping direction it was given
                  d.regs = REGS_RESET;
                  d.regs.ascend = byte_in[ASCEND_LO_BIT];
                end
              end else if (q.addr == IF_CONFIG_B_OFFSET) begin
                d.regs.one_instruction_only = byte_in[ONE_INSTRUCTION_BIT];
              end else if (q.addr == STREAM_SPAN_OFFSET) begin
                d.regs.stream_span = byte_in;
              end else if (q.addr == CHANNEL_ENABLE_CONFIG_OFFSET) begin
                d.regs.first_channel_sink_on = byte_in[SINK_ON_BIT]; // [RULE7]
                d.regs.out_run_n = byte_in[CHANNELS-1:0]; // [RULE8] [RULE12]
              end
            end
            d.done_one = 1'b1;
            if (q.regs.one_instruction_only) begin
              // later bytes of the frame neither move nor write
              d.addr = q.addr; // [RULE10]
            end else if ((q.regs.stream_span != 8'h00) &&
                         (q.steps >= q.regs.stream_span)) begin
              // all span steps taken, so the next byte restarts; >= also covers a span shrunk mid-frame
              d.addr = q.first_addr; // [RULE2]
              d.steps = 8'h00;
            end else begin
              // the 7-bit address wraps at either end of the space
              d.addr = q.regs.ascend ? q.addr + 7'h01 : q.addr - 7'h01; // [RULE9] [RULE3]
              d.steps = q.steps + 8'h01; // [RULE2]
            end
            d.tx = reg_read(d.addr, d.regs, q.not_ready);
          end
          default: begin
            d.phase = PH_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign spi_sdo_out = q.sdo;
  assign spi_sdo_oe_out = q.sdo_oe;
  assign first_channel_sink_on_out = q.regs.first_channel_sink_on;
  assign out_run_n_out = q.regs.out_run_n;

endmodule : stream_regs
`default_nettype wire

// [hw/stream_regs_pkg.sv]
package stream_regs_pkg;

  localparam logic [6:0] IF_CONFIG_A_OFFSET = 7'h00;
  localparam logic [6:0] IF_CONFIG_B_OFFSET = 7'h01;
  localparam logic [6:0] MAKER_CODE_LOW_OFFSET = 7'h0C;
  localparam logic [6:0] MAKER_CODE_HIGH_OFFSET = 7'h0D;
  localparam logic [6:0] STREAM_SPAN_OFFSET = 7'h0E;
  localparam logic [6:0] STRICT_WRITE_CONFIG_OFFSET = 7'h10;
  localparam logic [6:0] LINK_READY_STATUS_OFFSET = 7'h11;
  localparam logic [6:0] CHANNEL_ENABLE_CONFIG_OFFSET = 7'h14;

  localparam int SOFT_RESET_HI_BIT = 7;
  localparam int SOFT_RESET_LO_BIT = 0;
  localparam int ASCEND_HI_BIT = 5;
  localparam int ASCEND_LO_BIT = 2;
  localparam logic [7:0] IF_CONFIG_A_FIXED = 8'h18;
  localparam int ONE_INSTRUCTION_BIT = 7;
  localparam logic [7:0] IF_CONFIG_B_FIXED = 8'h08;
  localparam logic [7:0] STRICT_WRITE_CONFIG_RESET = 8'h20;
  localparam int NOT_READY_BIT = 7;
  localparam int SINK_ON_BIT = 7;
  localparam int CHANNELS = 6;
  localparam logic [7:0] CHANNEL_ENABLE_CONFIG_RESET = 8'h80;
  localparam logic [7:0] STREAM_SPAN_RESET = 8'h00;
  localparam int READ_FLAG_BIT = 7;
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_INSTR,
    PH_DATA
  } phase_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } spi_pins_type;

  typedef struct packed {
    logic ascend;
    logic one_instruction_only;
    logic [7:0] stream_span;
    logic first_channel_sink_on;
    logic [CHANNELS-1:0] out_run_n;
  } regs_type;

endpackage : stream_regs_pkg

// [sim/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clock_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // whole multibyte values in one frame, data bytes in address order
  task automatic frame(input logic [7:0] ins, input int n, input logic [23:0] wr,
                       output logic [23:0] rd);
    logic [31:0] tx;
    tx = {ins, wr};
    rd = 24'h000000;
    @(posedge clock_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i < 8 * (n + 1); i++) begin
      sdi_out <= tx[31-i];
      repeat (5) @(posedge clock_in);
      sclk_out <= 1'b1;
      if (i >= 8) rd[31-i] = sdo_in;
      repeat (5) @(posedge clock_in);
      sclk_out <= 1'b0;
    end
    repeat (5) @(posedge clock_in);
    cs_n_out <= 1'b1;
    // released line must not keep showing the last bit
    sdi_out <= ~sdi_out;
    repeat (8) @(posedge clock_in);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [sim/stream_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module stream_regs_asserts
  import stream_regs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  input wire logic core_busy_in,
  input wire logic spi_sdo_out,
  input wire logic spi_sdo_oe_out,
  input wire logic first_channel_sink_on_out,
  input wire logic [CHANNELS-1:0] out_run_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_reset_defaults: assert property ($fell(rst_in) |->
    first_channel_sink_on_out && out_run_n_out == 6'h00) else $error("bad reset outputs");
  // outputs move only through a write inside a frame
  a_sink_held: assert property ((spi_cs_n_in && $past(spi_cs_n_in, 8)) |->
    $stable(first_channel_sink_on_out)) else $error("sink moved outside frame");
  a_run_held: assert property ((spi_cs_n_in && $past(spi_cs_n_in, 8)) |->
    $stable(out_run_n_out)) else $error("run bits moved outside frame");
  a_sdo_steady: assert property (spi_sclk_in [*4] |-> $stable(spi_sdo_out))
    else $error("sdo moved while clock high");
  a_oe_rise: assert property ($rose(spi_sdo_oe_out) |-> !spi_cs_n_in && !spi_sclk_in)
    else $error("oe rose outside a falling edge");
  a_oe_frame_start: assert property ($fell(spi_cs_n_in) |-> (!spi_sdo_oe_out) [*8])
    else $error("oe high during instruction");
  a_oe_fall: assert property ($fell(spi_sdo_oe_out) |-> spi_cs_n_in)
    else $error("oe fell inside frame");
  a_oe_release: assert property (spi_cs_n_in [*6] |-> !spi_sdo_oe_out)
    else $error("oe held after frame");
endmodule : stream_regs_asserts
bind stream_regs stream_regs_asserts chk (.clock_in(clock_in), .rst_in(rst_in),
  .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in), .spi_sdi_in(spi_sdi_in),
  .core_busy_in(core_busy_in), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_out(spi_sdo_oe_out),
  .first_channel_sink_on_out(first_channel_sink_on_out), .out_run_n_out(out_run_n_out));
`default_nettype wire

// [sim/stream_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module stream_regs_bench;
  import stream_regs_pkg::*;
  localparam logic [15:0] CODE = 16'h5C3D;  // arbitrary value
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic core_busy_in = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, sink_on;
  logic [CHANNELS-1:0] run_n;
  logic [23:0] rd;
  logic [7:0] addr [3] = '{8'h8E, 8'h90, 8'h91};
  logic [7:0] expv [3] = '{8'h00, 8'h20, 8'h00};
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 clock_in = ~clock_in;
  stream_regs #(.MAKER_CODE(CODE)) dut (.clock_in(clock_in), .rst_in(rst_in),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .core_busy_in(core_busy_in),
    .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .first_channel_sink_on_out(sink_on),
    .out_run_n_out(run_n));
  // an undriven line reads as the inverse of the last bit, so a missing enable corrupts reads
  spi_host_model host (.clock_in(clock_in), .sdo_in(sdo_oe ? sdo : ~sdo), .sclk_out(sclk),
    .cs_n_out(cs_n),
    .sdi_out(sdi));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check(sink_on, 1'b1);
    check(run_n, 6'h00);
    host.frame(8'h8D, 2, 24'h0, rd);
    check(rd[23:8], CODE);
    foreach (addr[i]) begin
      host.frame(addr[i], 1, 24'h0, rd);
      check(rd[23:16], expv[i]);
    end
    core_busy_in <= 1'b1;
    host.frame(8'h91, 1, 24'h0, rd);  // only reads while busy
    check(rd[23:16], 8'h80);
    core_busy_in <= 1'b0;
    host.frame(8'h10, 1, 24'h0, rd);
    host.frame(8'h90, 1, 24'h0, rd);
    check(rd[23:16], 8'h20);
    host.frame(8'h14, 1, 24'h7F0000, rd);
    repeat (4) @(posedge clock_in);
    check(sink_on, 1'b0);
    check(run_n, 6'h3F);
    host.frame(8'h94, 1, 24'h0, rd);
    check(rd[23:16], 8'h3F);
    host.frame(8'h00, 1, 24'h240000, rd);
    host.frame(8'hFF, 2, 24'h0, rd);
    check(rd[23:8], 16'h003C);
    host.frame(8'h0E, 1, 24'h010000, rd);
    host.frame(8'h8C, 3, 24'h0, rd);
    check(rd, {CODE[7:0], CODE[15:8], CODE[7:0]});
    host.frame(8'h01, 1, 24'h800000, rd);
    host.frame(8'h14, 2, 24'h013F00, rd);
    repeat (4) @(posedge clock_in);
    check(run_n, 6'h01);
    check(sink_on, 1'b0);
    // soft reset: registers back to defaults, stepping direction kept
    host.frame(8'h00, 1, 24'hA50000, rd);
    repeat (4) @(posedge clock_in);
    check(sink_on, 1'b1);
    check(run_n, 6'h00);
    host.frame(8'h81, 1, 24'h0, rd);
    check(rd[23:16], 8'h08);
    host.frame(8'h8E, 1, 24'h0, rd);
    check(rd[23:16], 8'h00);
    host.frame(8'h80, 1, 24'h0, rd);
    check(rd[23:16], 8'h3C);
    conclude();
  end
endmodule : stream_regs_bench
`default_nettype wire
